// file: shared/bdm_pkg.sv
// package: constants and carrier types for the banked data memory addressing block
package bdm_pkg;
   // ***************************************************************
   // plane geometry
   // ***************************************************************
   localparam int unsigned ADDR_W       = 9;
   localparam int unsigned OFS_W        = 7;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned NUM_BANKS    = 4;
   localparam logic [6:0]  OFS_MAX      = 7'h7f;
   localparam logic [6:0]  GP_FIRST     = 7'h20;
   localparam logic [6:0]  GP_LAST      = 7'h6f;
   localparam logic [6:0]  COMMON_FIRST = 7'h70;
   localparam int unsigned GP_BYTES     = 80;
   localparam int unsigned COMMON_BYTES = 16;
   localparam int unsigned RAM_BYTES    = 3 * GP_BYTES + COMMON_BYTES;
   localparam int unsigned RAM_IDX_W    = 8;
   localparam logic [1:0]  UNUSED_BANK  = 2'h3;

   // ***************************************************************
   // register offsets (in-bank, mirrored in every bank)
   // ***************************************************************
   localparam logic [6:0] OFS_INDIRECT_DATA_PORT = 7'h00;
   localparam logic [6:0] OFS_CORE_FLAGS         = 7'h03;
   localparam logic [6:0] OFS_INDIRECT_POINTER   = 7'h04;

   // ***************************************************************
   // core flags field positions and reset values
   // ***************************************************************
   localparam int unsigned BIT_INDIRECT_PAGE     = 7;
   localparam int unsigned BIT_BANK_SELECT_HIGH  = 6;
   localparam int unsigned BIT_BANK_SELECT_LOW   = 5;
   localparam logic [7:0]  CORE_FLAGS_RESET      = 8'h00;
   localparam logic [7:0]  POINTER_RESET         = 8'h00;
   localparam logic [7:0]  RAM_RESET             = 8'h00;
   localparam logic [7:0]  NULL_READ             = 8'h00;
   localparam logic [7:0]  ALU_FLAG_MASK         = 8'h1f;

   // ***************************************************************
   // carrier types
   // ***************************************************************
   typedef enum logic [1:0] {
      BDM_MODE_BANKED = 2'b00,
      BDM_MODE_FULL   = 2'b01
   } bdm_mode_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      bdm_mode_t   mode;
      logic [8:0]  addr;
      logic [7:0]  wdata;
   } bdm_req_t;

   typedef struct packed {
      logic        valid;
      logic [8:0]  addr;
      logic [7:0]  rdata;
      logic        is_sfr;
   } bdm_rsp_t;

   typedef enum logic [1:0] {
      BDM_ST_IDLE   = 2'b00,
      BDM_ST_ANSWER = 2'b01
   } bdm_state_t;
endpackage

// file: verilog/bdm_addressing.sv
// design: address generation and decode for the banked cpu data memory plane
//
// Summary of operation
// - four banks of 128 byte locations each
// - sfrs low, general ram above in banks 0-2, 80 bytes
// - status bits 6:5 select direct bank
// - common sfrs mirrored into every bank
// - indirect port reaches register at pointer address
// - pointer zero: indirect read returns 00h
// - pointer zero: indirect write stores nothing
// - indirect address is page bit plus pointer
// - full address variants need no bank switching
// - full address 10fh reaches bank 2 register
`timescale 1ns/1ps
`default_nettype none

module bdm_addressing (
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   input  wire bdm_pkg::bdm_req_t req,
   input  wire logic [7:0]        flag_update,
   input  wire logic              flag_update_en,
   output var  bdm_pkg::bdm_rsp_t rsp,
   output var  logic [7:0]        sfr_wdata,
   output var  logic [8:0]        sfr_addr,
   output var  logic              sfr_wr,
   output var  logic              sfr_rd,
   input  wire logic [7:0]        sfr_rdata,
   output var  logic [7:0]        core_flags,
   output var  logic [7:0]        pointer
);

   // ***************************************************************
   // state
   // ***************************************************************
   logic [7:0] flags_q, flags_d;
   logic [7:0] ptr_q, ptr_d;
   logic [7:0] ram_q [bdm_pkg::RAM_BYTES];
   logic [7:0] ram_d [bdm_pkg::RAM_BYTES];
   bdm_pkg::bdm_rsp_t  rsp_q, rsp_d;
   bdm_pkg::bdm_state_t st_q, st_d;
   logic [7:0] sfr_wdata_q, sfr_wdata_d;
   logic [8:0] sfr_addr_q, sfr_addr_d;
   logic       sfr_wr_q, sfr_wr_d;
   logic       sfr_rd_q, sfr_rd_d;

   // ***************************************************************
   // address formation
   // ***************************************************************
   logic [8:0] first_addr;
   logic [8:0] eff_addr;
   logic       via_port;
   logic       null_access;
   logic [6:0] ofs;
   logic [1:0] bank;
   logic       is_ram;
   logic       is_local_reg;
   logic [7:0] ram_idx;

   always_comb begin
      if (req.mode == bdm_pkg::BDM_MODE_FULL) begin
         first_addr = req.addr;
      end else begin
         first_addr = {flags_q[bdm_pkg::BIT_BANK_SELECT_HIGH],
                       flags_q[bdm_pkg::BIT_BANK_SELECT_LOW],
                       req.addr[6:0]};
      end
      via_port = (first_addr[6:0] == bdm_pkg::OFS_INDIRECT_DATA_PORT);
      if (via_port) begin
         eff_addr = {flags_q[bdm_pkg::BIT_INDIRECT_PAGE], ptr_q};
      end else begin
         eff_addr = first_addr;
      end
      // a pointer that lands on the port itself in any bank addresses nothing
      null_access = via_port && (eff_addr[6:0] == bdm_pkg::OFS_INDIRECT_DATA_PORT);
      ofs  = eff_addr[6:0];
      bank = eff_addr[8:7];
   end

   // ***************************************************************
   // decode: common area, general ram, local registers, sfr bus
   // ***************************************************************
   always_comb begin
      is_ram       = 1'b0;
      is_local_reg = 1'b0;
      ram_idx      = 8'h00;
      if (ofs >= bdm_pkg::COMMON_FIRST) begin
         is_ram  = 1'b1;
         ram_idx = 8'(3 * bdm_pkg::GP_BYTES) + 8'(ofs - bdm_pkg::COMMON_FIRST);
      end else if (ofs >= bdm_pkg::GP_FIRST && bank != bdm_pkg::UNUSED_BANK) begin
         is_ram  = 1'b1;
         ram_idx = 8'(bank) * 8'(bdm_pkg::GP_BYTES) + 8'(ofs - bdm_pkg::GP_FIRST);
      end else if (ofs == bdm_pkg::OFS_CORE_FLAGS || ofs == bdm_pkg::OFS_INDIRECT_POINTER) begin
         is_local_reg = 1'b1;
      end
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   logic [7:0] local_rd;
   logic       hit_unused;

   always_comb begin
      flags_d     = flags_q;
      ptr_d       = ptr_q;
      ram_d       = ram_q;
      rsp_d       = '0;
      st_d        = bdm_pkg::BDM_ST_IDLE;
      sfr_wdata_d = sfr_wdata_q;
      sfr_addr_d  = sfr_addr_q;
      sfr_wr_d    = 1'b0;
      sfr_rd_d    = 1'b0;
      local_rd    = (ofs == bdm_pkg::OFS_CORE_FLAGS) ? flags_q : ptr_q;
      // bank 3 general area is left unused: reads 00h, writes dropped
      hit_unused  = (bank == bdm_pkg::UNUSED_BANK) && !is_ram &&
                    (ofs >= bdm_pkg::GP_FIRST);

      // alu flags from the datapath; bank and page bits stay software owned
      if (flag_update_en) begin
         flags_d = (flags_q & ~bdm_pkg::ALU_FLAG_MASK) |
                   (flag_update & bdm_pkg::ALU_FLAG_MASK);
      end

      case (st_q)
         bdm_pkg::BDM_ST_IDLE: begin
            if (req.valid) begin
               rsp_d.addr = eff_addr;
               if (null_access) begin
                  rsp_d.valid = 1'b1;
                  rsp_d.rdata = bdm_pkg::NULL_READ;
               end else if (is_ram) begin
                  rsp_d.valid = 1'b1;
                  if (req.write) begin
                     ram_d[ram_idx] = req.wdata;
                  end
                  rsp_d.rdata = ram_q[ram_idx];
               end else if (is_local_reg) begin
                  rsp_d.valid  = 1'b1;
                  rsp_d.is_sfr = 1'b1;
                  rsp_d.rdata  = local_rd;
                  if (req.write && ofs == bdm_pkg::OFS_CORE_FLAGS) begin
                     flags_d = req.wdata;
                  end else if (req.write) begin
                     ptr_d = req.wdata;
                  end
               end else if (hit_unused) begin
                  rsp_d.valid = 1'b1;
                  rsp_d.rdata = bdm_pkg::NULL_READ;
               end else begin
                  // peripheral sfr: hand off, answer when its data returns
                  sfr_addr_d  = eff_addr;
                  sfr_wdata_d = req.wdata;
                  sfr_wr_d    = req.write;
                  sfr_rd_d    = !req.write;
                  st_d        = bdm_pkg::BDM_ST_ANSWER;
               end
            end
         end
         bdm_pkg::BDM_ST_ANSWER: begin
            rsp_d.valid  = 1'b1;
            rsp_d.is_sfr = 1'b1;
            rsp_d.addr   = sfr_addr_q;
            rsp_d.rdata  = sfr_rd_q ? sfr_rdata : 8'h00;
         end
         default: begin
            st_d = bdm_pkg::BDM_ST_IDLE;
         end
      endcase
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         flags_q     <= bdm_pkg::CORE_FLAGS_RESET;
         ptr_q       <= bdm_pkg::POINTER_RESET;
         rsp_q       <= '0;
         st_q        <= bdm_pkg::BDM_ST_IDLE;
         sfr_wdata_q <= 8'h00;
         sfr_addr_q  <= 9'h000;
         sfr_wr_q    <= 1'b0;
         sfr_rd_q    <= 1'b0;
      end else begin
         flags_q     <= flags_d;
         ptr_q       <= ptr_d;
         rsp_q       <= rsp_d;
         st_q        <= st_d;
         sfr_wdata_q <= sfr_wdata_d;
         sfr_addr_q  <= sfr_addr_d;
         sfr_wr_q    <= sfr_wr_d;
         sfr_rd_q    <= sfr_rd_d;
      end
   end

   // ram contents are not cleared by reset on real parts; cleared here for determinism
   genvar gi;
   generate
      for (gi = 0; gi < bdm_pkg::RAM_BYTES; gi++) begin : g_ram
         always_ff @(posedge sys_clk) begin
            if (!nrst) begin
               ram_q[gi] <= bdm_pkg::RAM_RESET;
            end else begin
               ram_q[gi] <= ram_d[gi];
            end
         end
      end
   endgenerate

   assign rsp        = rsp_q;
   assign sfr_wdata  = sfr_wdata_q;
   assign sfr_addr   = sfr_addr_q;
   assign sfr_wr     = sfr_wr_q;
   assign sfr_rd     = sfr_rd_q;
   assign core_flags = flags_q;
   assign pointer    = ptr_q;

endmodule

`default_nettype wire

// file: tb/bdm_checker.sv
// checker: port relations of the banked data memory addressing block
`timescale 1ns/1ps
`default_nettype none
module bdm_checker (
   input wire logic              sys_clk,
   input wire logic              nrst,
   input wire bdm_pkg::bdm_req_t req,
   input wire logic [7:0]        flag_update,
   input wire logic              flag_update_en,
   input wire bdm_pkg::bdm_rsp_t rsp,
   input wire logic [7:0]        sfr_wdata,
   input wire logic [8:0]        sfr_addr,
   input wire logic              sfr_wr,
   input wire logic              sfr_rd,
   input wire logic [7:0]        sfr_rdata,
   input wire logic [7:0]        core_flags,
   input wire logic [7:0]        pointer
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic go;
   logic ram;
   // a request is only taken while no peripheral access is pending
   assign go = req.valid && !sfr_rd && !sfr_wr;
   assign ram = req.addr[6:5] != 2'h0 && req.addr[6:4] != 3'h7;
   sfr_read_a: assert property (sfr_rd |=>
      rsp.valid && rsp.is_sfr && rsp.rdata == $past(sfr_rdata)) else $error("bad sfr read");
   sfr_write_a: assert property (sfr_wr |=> rsp.valid && rsp.is_sfr)
      else $error("bad sfr write answer");
   direct_addr_a: assert property (go && req.mode == bdm_pkg::BDM_MODE_BANKED && ram |=>
      rsp.valid && rsp.addr == {$past(core_flags[6:5]), $past(req.addr[6:0])})
      else $error("bad direct address");
   full_addr_a: assert property (go && req.mode == bdm_pkg::BDM_MODE_FULL && ram |=>
      rsp.valid && rsp.addr == $past(req.addr)) else $error("bad full address");
   indirect_addr_a: assert property (go && req.addr[6:0] == 7'h00 && pointer[6:5] != 2'h0
      && pointer[6:4] != 3'h7 |=> rsp.addr == {$past(core_flags[7]), $past(pointer)})
      else $error("bad indirect address");
   null_read_a: assert property (go && !req.write && req.addr[6:0] == 7'h00
      && pointer[6:0] == 7'h00 |=> rsp.valid && rsp.rdata == 8'h00) else $error("bad null read");
   reset_state_a: assert property (disable iff (1'b0) !nrst |=> core_flags == 8'h00
      && pointer == 8'h00 && !rsp.valid && !sfr_rd && !sfr_wr) else $error("bad reset");
   flag_update_a: assert property (flag_update_en && !req.valid |=>
      core_flags == {$past(core_flags[7:5]), $past(flag_update[4:0])}) else $error("bad flags");
   cover property (sfr_rd);
   cover property (go && req.addr[6:0] == 7'h00 && pointer == 8'h00);
   cover property (flag_update_en);
endmodule
`default_nettype wire

// file: tb/bdm_sfr_model.sv
// partner: peripheral special function registers behind the addressing block
`timescale 1ns/1ps
`default_nettype none
module bdm_sfr_model (
   input  wire logic       sys_clk,
   input  wire logic [8:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   output var  logic [7:0] sfr_rdata
);
   logic [7:0] mem [512];
   initial foreach (mem[i]) mem[i] = 8'h00;
   always @(posedge sys_clk) if (sfr_wr) mem[sfr_addr] <= sfr_wdata;
   // outside a read the bus shows inverted data, so a stale capture is caught
   assign sfr_rdata = sfr_rd ? mem[sfr_addr] : ~mem[sfr_addr];
endmodule
`default_nettype wire

// file: tb/banked_data_memory_addressing_bench.sv
// bench: table-driven checks of the banked data memory addressing block
`timescale 1ns/1ps
`default_nettype none
`define chk(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
   $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module banked_data_memory_addressing_bench;
   typedef struct packed {
      logic w; logic m; logic [8:0] a; logic [7:0] d; logic [8:0] ea; logic [7:0] er; logic cr;
   } bdm_row_t;
   logic              sys_clk, nrst, flag_update_en, sfr_wr, sfr_rd;
   logic [7:0]        flag_update, sfr_wdata, sfr_rdata, core_flags, pointer;
   logic [8:0]        sfr_addr;
   bdm_pkg::bdm_req_t req;
   bdm_pkg::bdm_rsp_t rsp, got;
   int                fails = 0, comparisons = 0;
   bdm_row_t          rows [21];
   bdm_addressing i_bdm_addressing (.sys_clk(sys_clk), .nrst(nrst), .req(req),
      .flag_update(flag_update), .flag_update_en(flag_update_en), .rsp(rsp),
      .sfr_wdata(sfr_wdata), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata), .core_flags(core_flags), .pointer(pointer));
   bdm_sfr_model i_bdm_sfr_model (.sys_clk(sys_clk), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic summarize();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // one access, held for one clock, then wait up to 3 clocks for the answer
   task automatic acc(input logic w, input logic m, input logic [8:0] a, input logic [7:0] d);
      int n;
      @(posedge sys_clk) #1;
      req = '{1'b1, w, bdm_pkg::bdm_mode_t'({1'b0, m}), a, d};
      @(posedge sys_clk) #1;
      req.valid = 1'b0;
      n = 0;
      while (rsp.valid !== 1'b1 && n < 3) begin
         @(posedge sys_clk) #1;
         n++;
      end
      got = rsp;
   endtask
   initial begin
      repeat (1000) @(posedge sys_clk);
      fails++;
      summarize();
   end
   initial begin
      nrst = 1'b0;
      req = '0;
      flag_update = 8'h00;
      flag_update_en = 1'b0;
      rows = '{'{1,0,9'h020,8'h16,9'h020,8'h00,1}, '{0,1,9'h020,8'h00,9'h020,8'h16,1},
         '{1,1,9'h0a0,8'h37,9'h0a0,8'h00,0}, '{1,0,9'h003,8'h20,9'h003,8'h00,0},
         '{0,0,9'h020,8'h00,9'h0a0,8'h37,1}, '{1,0,9'h004,8'h25,9'h084,8'h00,0},
         '{1,0,9'h003,8'h80,9'h083,8'h00,0}, '{1,0,9'h000,8'h77,9'h125,8'h00,0},
         '{0,1,9'h125,8'h00,9'h125,8'h77,1}, '{0,1,9'h184,8'h00,9'h184,8'h25,1},
         '{1,1,9'h10f,8'h0b,9'h10f,8'h00,0}, '{0,1,9'h10f,8'h00,9'h10f,8'h0b,1},
         '{0,0,9'h00f,8'h00,9'h00f,8'h00,1}, '{1,1,9'h004,8'h00,9'h004,8'h00,0},
         '{0,0,9'h000,8'h00,9'h100,8'h00,1}, '{1,0,9'h000,8'h99,9'h100,8'h00,0},
         '{0,1,9'h020,8'h00,9'h020,8'h16,1}, '{1,1,9'h1a0,8'h55,9'h1a0,8'h00,0},
         '{0,1,9'h1a0,8'h00,9'h1a0,8'h00,1}, '{1,1,9'h170,8'h5a,9'h170,8'h00,0},
         '{0,0,9'h070,8'h00,9'h070,8'h5a,1}};
      repeat (12) @(posedge sys_clk);
      #1 nrst = 1'b1;
      foreach (rows[i]) begin
         acc(rows[i].w, rows[i].m, rows[i].a, rows[i].d);
         `chk(got.valid, 1'b1)
         `chk(got.addr, rows[i].ea)
         if (rows[i].cr) `chk(got.rdata, rows[i].er)
      end
      `chk(sfr_addr, 9'h00f)
      `chk(sfr_wdata, 8'h00)
      @(posedge sys_clk) #1;
      flag_update = 8'h1f;
      flag_update_en = 1'b1;
      @(posedge sys_clk) #1;
      flag_update_en = 1'b0;
      `chk(core_flags, 8'h9f)
      nrst = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 nrst = 1'b1;
      `chk(core_flags, 8'h00)
      `chk(pointer, 8'h00)
      acc(1'b0, 1'b1, 9'h020, 8'h00);
      `chk(got.rdata, 8'h00)
      summarize();
   end
endmodule
bind bdm_addressing bdm_checker i_bdm_checker (.sys_clk(sys_clk), .nrst(nrst), .req(req),
   .flag_update(flag_update), .flag_update_en(flag_update_en), .rsp(rsp),
   .sfr_wdata(sfr_wdata), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_rdata(sfr_rdata), .core_flags(core_flags), .pointer(pointer));
`default_nettype wire
